//--- hdl/ptpirq_pkg.sv
// Purpose: Shared constants for the time-protocol event interrupt block.
// Assumes: 10 MHz system clock, 12-bit Wishbone byte address.
// Notes:   Flag n and enable n+16 share one source order.
package ptpirq_pkg;

  // Clock and pulse timing
  localparam int CLK_MHZ   = 10;
  localparam int PULSE_NS  = 100;
  localparam int PULSE_RAW = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYC = (PULSE_RAW < 1) ? 1 : PULSE_RAW;

  // Register byte offsets
  localparam logic [11:0] OFF_EVT_STS_EN = 12'h198;
  localparam logic [11:0] OFF_SYS_STS    = 12'h058;
  localparam logic [11:0] OFF_SYS_EN     = 12'h05C;
  localparam logic [11:0] OFF_PIN_CFG    = 12'h060;

  // Event status / enable layout
  localparam int NUM_SRC     = 9;
  localparam int EN_LSB      = 16;
  localparam int SUMMARY_BIT = 29;

  // Source positions inside the status field
  localparam int FLG_TIMER = 0;
  localparam int FLG_PIN8  = 1;
  localparam int FLG_PIN9  = 2;
  localparam int FLG_HM_TX = 3;
  localparam int FLG_HM_RX = 4;
  localparam int FLG_P1_TX = 5;
  localparam int FLG_P1_RX = 6;
  localparam int FLG_P2_TX = 7;
  localparam int FLG_P2_RX = 8;

  // Pin configuration layout, pin 0 = GPIO 8, pin 1 = GPIO 9
  localparam int NUM_PIN        = 2;
  localparam int CFG_CAP_LSB    = 0;
  localparam int CFG_CLR_LSB    = 2;
  localparam int CFG_INPOL_LSB  = 4;
  localparam int CFG_MODE_LSB   = 6;
  localparam int CFG_OE_LSB     = 10;
  localparam int CFG_OUTPOL_LSB = 12;
  localparam int CFG_W          = 14;

  // Reset values
  localparam logic [NUM_SRC-1:0] STS_RST    = 9'h000;
  localparam logic [NUM_SRC-1:0] EN_RST     = 9'h000;
  localparam logic [CFG_W-1:0]   CFG_RST    = 14'h0000;
  localparam logic               SYS_EN_RST = 1'b0;

  // Pin clock event output modes
  typedef enum logic [1:0] {
    PTPIRQ_MODE_PULSE  = 2'h0,
    PTPIRQ_MODE_TOGGLE = 2'h1,
    PTPIRQ_MODE_FLAG   = 2'h2,
    PTPIRQ_MODE_RSVD   = 2'h3
  } ptpirq_mode_t;

endpackage : ptpirq_pkg

//--- hdl/ptpirq_sync.sv
// Purpose: Two-flop synchroniser with edge detection for pin inputs.
// Assumes: Inputs asynchronous to clk_i.
// Notes:   Edges are taken from the second and third stages only.
`timescale 1ns/10ps
`default_nettype none
module ptpirq_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Asynchronous input
  input  wire logic [WIDTH-1:0] async_i,
  // Synchronised level and edges
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stab_r;
  logic [WIDTH-1:0] prev_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      stab_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= async_i;
      stab_r <= meta_r;
      prev_r <= stab_r;
    end
  end

  assign level_o = stab_r;
  assign rise_o  = stab_r & ~prev_r;
  assign fall_o  = ~stab_r & prev_r;

endmodule : ptpirq_sync
`default_nettype wire

//--- hdl/ptpirq_top.sv
// Purpose: Time-protocol event interrupt status, enables and summary.
// Assumes: Classic Wishbone slave, capture strobes are one-cycle pulses.
// Notes:   Pin inputs are sampled at 10 MHz; pulses under 100 ns may be missed.
// Contract
// - Writing one to a status flag clears it; zero leaves it.
// - Enabled flags are ORed into summary bit 29 of system status.
// - Flags set on their event regardless of enable; enables gate summary only.
// - System interrupt raised only when summary and enable bit 29 both set.
// - Nine R/W enables at bits 24..16, reset zero, enable n+16 gates flag n.
// - Port 2 receive capture sets bit 8, transmit capture sets bit 7.
// - Port 1 receive capture sets bit 6, transmit capture sets bit 5.
// - Host port: fabric-to-host sets bit 4, host-to-fabric sets bit 3.
// - Pin 9 capture sets bit 2, pin 8 capture sets bit 1.
// - Bit 0 sets when clock reaches or passes the 64-bit target.
// - Enabled pin 9 or 8 active edge also clears the timer flag.
// - Pin mode code 10 drives the current timer flag onto the pin.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module ptpirq_top (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Capture strobes from the timestamp datapath
  input  wire logic        p2_rx_capture_i,
  input  wire logic        p2_tx_capture_i,
  input  wire logic        p1_rx_capture_i,
  input  wire logic        p1_tx_capture_i,
  input  wire logic        host_rx_capture_i,
  input  wire logic        host_tx_capture_i,
  // Running clock and target
  input  wire logic [63:0] ptp_clock_i,
  input  wire logic [31:0] clock_target_upper_i,
  input  wire logic [31:0] clock_target_lower_i,
  // Pins 8 and 9, index 0 is pin 8
  input  wire logic [1:0]  pin_i,
  output logic      [1:0]  pin_o,
  output logic      [1:0]  pin_oe_o,
  // System interrupt
  output logic             irq_o
);

  // Register state
  logic [ptpirq_pkg::NUM_SRC-1:0] sts_r;
  logic [ptpirq_pkg::NUM_SRC-1:0] sts_nxt;
  logic [ptpirq_pkg::NUM_SRC-1:0] en_r;
  logic [ptpirq_pkg::NUM_SRC-1:0] en_nxt;
  logic [ptpirq_pkg::CFG_W-1:0]   cfg_r;
  logic [ptpirq_pkg::CFG_W-1:0]   cfg_nxt;
  logic                           sys_en_r;
  logic                           sys_en_nxt;
  logic                           ack_r;
  logic [31:0]                    dat_r;
  logic                           irq_r;
  logic                           irq_nxt;
  logic                           ge_prev_r;
  logic [2:0]                     arm_r;

  // Bus decode
  wire logic [11:0] adr_w    = {wb_adr_i[11:2], 2'b00};
  wire logic        req_w    = wb_cyc_i & wb_stb_i & ~ack_r;
  wire logic        wr_w     = req_w & wb_we_i;
  wire logic        rd_w     = req_w & ~wb_we_i;
  wire logic        hit_evt  = (adr_w == ptpirq_pkg::OFF_EVT_STS_EN);
  wire logic        hit_ssts = (adr_w == ptpirq_pkg::OFF_SYS_STS);
  wire logic        hit_sen  = (adr_w == ptpirq_pkg::OFF_SYS_EN);
  wire logic        hit_cfg  = (adr_w == ptpirq_pkg::OFF_PIN_CFG);

  // Byte-lane masked write data
  wire logic [31:0] lane_w = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                              {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic [31:0] wmask_w = wb_dat_i & lane_w;
  wire logic        wr_evt  = wr_w & hit_evt;
  wire logic        wr_sen  = wr_w & hit_sen;
  wire logic        wr_cfg  = wr_w & hit_cfg;

  // Pin configuration fields
  wire logic [1:0] cap_en_w  = cfg_r[ptpirq_pkg::CFG_CAP_LSB +: 2];
  wire logic [1:0] clr_en_w  = cfg_r[ptpirq_pkg::CFG_CLR_LSB +: 2];
  wire logic [1:0] in_pol_w  = cfg_r[ptpirq_pkg::CFG_INPOL_LSB +: 2];
  wire logic [1:0] oe_cfg_w  = cfg_r[ptpirq_pkg::CFG_OE_LSB +: 2];
  wire logic [1:0] out_pol_w = cfg_r[ptpirq_pkg::CFG_OUTPOL_LSB +: 2];

  // Pin input synchronisation
  logic [1:0] pin_lvl_w;
  logic [1:0] pin_rise_w;
  logic [1:0] pin_fall_w;

  ptpirq_sync #(
    .WIDTH (ptpirq_pkg::NUM_PIN)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (pin_i),
    .level_o (pin_lvl_w),
    .rise_o  (pin_rise_w),
    .fall_o  (pin_fall_w)
  );

  // Active edge per polarity; ignored while the block drives the pin
  wire logic [1:0] pin_edge_w = ((pin_rise_w & ~in_pol_w) | (pin_fall_w & in_pol_w))
                                & ~oe_cfg_w & {ptpirq_pkg::NUM_PIN{arm_r[2]}};
  wire logic [1:0] pin_cap_w  = pin_edge_w & cap_en_w;
  wire logic       pin_clr_w  = |(pin_edge_w & clr_en_w);

  // Clock target compare, event on the rising edge of the level
  wire logic [63:0] target_w  = {clock_target_upper_i, clock_target_lower_i};
  wire logic        ge_w      = (ptp_clock_i >= target_w);
  wire logic        timer_evt = ge_w & ~ge_prev_r;

  // Set vector in flag order
  wire logic [ptpirq_pkg::NUM_SRC-1:0] set_w = {
    p2_rx_capture_i,
    p2_tx_capture_i,
    p1_rx_capture_i,
    p1_tx_capture_i,
    host_rx_capture_i,
    host_tx_capture_i,
    pin_cap_w[1],
    pin_cap_w[0],
    timer_evt
  };

  // Clear vector: software one-writes plus pin clear of the timer flag
  wire logic [ptpirq_pkg::NUM_SRC-1:0] sw_clr_w =
    wr_evt ? wmask_w[ptpirq_pkg::NUM_SRC-1:0] : '0;
  wire logic [ptpirq_pkg::NUM_SRC-1:0] pin_clr_vec_w =
    {{(ptpirq_pkg::NUM_SRC-1){1'b0}}, pin_clr_w};
  wire logic [ptpirq_pkg::NUM_SRC-1:0] clr_w = sw_clr_w | pin_clr_vec_w;

  // Enable and config byte-lane merges
  wire logic [ptpirq_pkg::NUM_SRC-1:0] en_lane_w =
    lane_w[ptpirq_pkg::EN_LSB +: ptpirq_pkg::NUM_SRC];
  wire logic [ptpirq_pkg::NUM_SRC-1:0] en_data_w =
    wb_dat_i[ptpirq_pkg::EN_LSB +: ptpirq_pkg::NUM_SRC];
  wire logic [ptpirq_pkg::CFG_W-1:0] cfg_lane_w = lane_w[ptpirq_pkg::CFG_W-1:0];
  wire logic [ptpirq_pkg::CFG_W-1:0] cfg_data_w = wb_dat_i[ptpirq_pkg::CFG_W-1:0];
  wire logic sen_lane_w = lane_w[ptpirq_pkg::SUMMARY_BIT];
  wire logic sen_data_w = wb_dat_i[ptpirq_pkg::SUMMARY_BIT];

  // Next-state terms; a set in the clear cycle wins
  assign sts_nxt    = (sts_r & ~clr_w) | set_w;
  assign en_nxt     = wr_evt ? ((en_r & ~en_lane_w) | (en_data_w & en_lane_w))
                             : en_r;
  assign cfg_nxt    = wr_cfg ? ((cfg_r & ~cfg_lane_w) | (cfg_data_w & cfg_lane_w))
                             : cfg_r;
  assign sys_en_nxt = (wr_sen & sen_lane_w) ? sen_data_w : sys_en_r;

  // Summary and system interrupt
  wire logic summary_w = |(sts_r & en_r);
  assign irq_nxt = (|(sts_nxt & en_nxt)) & sys_en_nxt;

  // Read data; reserved bits and unmapped offsets return zero
  wire logic [31:0] rd_evt_w = {7'h00, en_r, 7'h00, sts_r};
  wire logic [31:0] rd_ssts_w = {2'h0, summary_w, 29'h00000000};
  wire logic [31:0] rd_sen_w = {2'h0, sys_en_r, 29'h00000000};
  wire logic [31:0] rd_cfg_w = {{(32-ptpirq_pkg::CFG_W){1'b0}}, cfg_r};
  wire logic [31:0] rdata_w = hit_evt  ? rd_evt_w  :
                              hit_ssts ? rd_ssts_w :
                              hit_sen  ? rd_sen_w  :
                              hit_cfg  ? rd_cfg_w  : 32'h00000000;

  // Status flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sts_r <= ptpirq_pkg::STS_RST;
    end else begin
      sts_r <= sts_nxt;
    end
  end

  // Source enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_r <= ptpirq_pkg::EN_RST;
    end else begin
      en_r <= en_nxt;
    end
  end

  // Pin configuration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= ptpirq_pkg::CFG_RST;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // System enable bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_en_r <= ptpirq_pkg::SYS_EN_RST;
    end else begin
      sys_en_r <= sys_en_nxt;
    end
  end

  // System interrupt level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // Bus acknowledge, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req_w;
    end
  end

  // Read data, zero outside a read answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h00000000;
    end else begin
      dat_r <= rd_w ? rdata_w : 32'h00000000;
    end
  end

  // Compare level history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ge_prev_r <= 1'b0;
    end else begin
      ge_prev_r <= ge_w;
    end
  end

  // Pin edge arming; sync flops restart at zero, so a high pin would fake a rise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arm_r <= 3'h0;
    end else begin
      arm_r <= {arm_r[1:0], 1'b1};
    end
  end

  // Pin clock event outputs
  localparam logic [3:0] PULSE_LEN = 4'(ptpirq_pkg::PULSE_CYC);

  genvar gi;
  generate
    for (gi = 0; gi < ptpirq_pkg::NUM_PIN; gi++) begin : g_pin
      logic       tog_r;
      logic [3:0] pcnt_r;
      logic       out_r;
      logic       oe_r;
      logic       lvl_w;
      ptpirq_pkg::ptpirq_mode_t mode_w;

      assign mode_w = ptpirq_pkg::ptpirq_mode_t'(
        cfg_r[ptpirq_pkg::CFG_MODE_LSB + 2*gi +: 2]);

      always_comb begin
        unique case (mode_w)
          ptpirq_pkg::PTPIRQ_MODE_PULSE:  lvl_w = (pcnt_r != 4'h0);
          ptpirq_pkg::PTPIRQ_MODE_TOGGLE: lvl_w = tog_r;
          ptpirq_pkg::PTPIRQ_MODE_FLAG:   lvl_w = sts_r[ptpirq_pkg::FLG_TIMER];
          ptpirq_pkg::PTPIRQ_MODE_RSVD:   lvl_w = 1'b0;
        endcase
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          tog_r  <= 1'b0;
          pcnt_r <= 4'h0;
          out_r  <= 1'b0;
          oe_r   <= 1'b0;
        end else begin
          if (timer_evt) begin
            tog_r  <= ~tog_r;
            pcnt_r <= PULSE_LEN;
          end else if (pcnt_r != 4'h0) begin
            pcnt_r <= pcnt_r - 4'h1;
          end
          out_r <= lvl_w ^ out_pol_w[gi];
          oe_r  <= oe_cfg_w[gi];
        end
      end

      assign pin_o[gi]    = out_r;
      assign pin_oe_o[gi] = oe_r;
    end
  endgenerate

  // Outputs
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign irq_o    = irq_r;

endmodule : ptpirq_top
`default_nettype wire

//--- sim/ptpirq_props.sv
// Purpose: Port assertions for the event interrupt block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to ptpirq_top.
`timescale 1ns/10ps
`default_nettype none
module ptpirq_props (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Bus
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  // Pins and interrupt
  input  wire logic [1:0]  pin_oe_o,
  input  wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic rd_ack = wb_ack_o && !wb_we_i;

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  ack_delay_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  ack_request_a: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
    else $error("ack without request");
  dat_quiet_a: assert property (!rd_ack |-> wb_dat_o == 32'h0)
    else $error("read data outside read ack");
  resv_zero_a: assert property (rd_ack && wb_adr_i[11:2] == 10'h066
    |-> wb_dat_o[31:25] == 7'h00 && wb_dat_o[15:9] == 7'h00)
    else $error("reserved bits not zero");
  summary_only_a: assert property (rd_ack && wb_adr_i[11:2] == 10'h016
    |-> wb_dat_o[28:0] == 29'h0 && wb_dat_o[31:30] == 2'h0)
    else $error("system status stray bits");
  reset_exit_a: assert property ($fell(rst_i) |-> !irq_o && pin_oe_o == 2'h0)
    else $error("outputs active after reset");
  oe_by_write_a: assert property ($changed(pin_oe_o) |-> wb_ack_o || $past(wb_ack_o))
    else $error("pin enable changed without write");
endmodule : ptpirq_props

bind ptpirq_top ptpirq_props u_ptpirq_props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_oe_o(pin_oe_o), .irq_o(irq_o));
`default_nettype wire

//--- sim/tb_ptpirq_top.sv
// Purpose: Register-level tests of the event interrupt block.
// Assumes: 10 MHz clock, classic Wishbone, all byte lanes on.
// Notes:   Capture strobe k sets status bit k+3.
`timescale 1ns/10ps
`default_nettype none
module tb_ptpirq_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, rd;
  logic        wb_ack_o, irq_o;
  logic [5:0]  cap = 6'h00;
  logic [63:0] ptp_clock_i = 64'h0;
  logic [63:0] tgt = 64'h100;
  logic [1:0]  pin_i = 2'h0;
  logic [1:0]  pin_o, pin_oe_o;
  int          error_cnt = 0;
  int          cmp_count = 0;

  always #50 clk_i = ~clk_i;

  ptpirq_top u_ptpirq_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .p2_rx_capture_i(cap[5]), .p2_tx_capture_i(cap[4]), .p1_rx_capture_i(cap[3]),
    .p1_tx_capture_i(cap[2]), .host_rx_capture_i(cap[1]), .host_tx_capture_i(cap[0]),
    .ptp_clock_i(ptp_clock_i), .clock_target_upper_i(tgt[63:32]),
    .clock_target_lower_i(tgt[31:0]), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .irq_o(irq_o));

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : xfer

  task rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rchk

  task pulse(input logic [5:0] c);
    @(posedge clk_i);
    cap <= c;
    @(posedge clk_i);
    cap <= 6'h00;
  endtask : pulse

  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  initial begin
    repeat (3000) @(posedge clk_i);
    error_cnt++;
    summarize();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk("sts_en reset", 12'h198, 32'h0);
    rchk("sys_en reset", 12'h05C, 32'h0);
    xfer(1'b1, 12'h198, 32'hFFFF_FFFF);
    rchk("enables rw", 12'h198, 32'h01FF_0000);
    xfer(1'b1, 12'h198, 32'h0);
    for (int k = 0; k < 6; k++) begin
      pulse(6'(1 << k));
      xfer(1'b1, 12'h198, 32'h0);
      rchk("capture flag", 12'h198, 32'(1 << (k + 3)));
      chk("irq masked", 32'h0, {31'h0, irq_o});
      xfer(1'b1, 12'h198, 32'(1 << (k + 3)));
      rchk("flag cleared", 12'h198, 32'h0);
    end
    xfer(1'b1, 12'h198, 32'h0040_0000);
    pulse(6'h08);
    rchk("summary", 12'h058, 32'h2000_0000);
    chk("irq sys off", 32'h0, {31'h0, irq_o});
    xfer(1'b1, 12'h05C, 32'h2000_0000);
    chk("irq on", 32'h1, {31'h0, irq_o});
    xfer(1'b1, 12'h198, 32'h0);
    rchk("summary off", 12'h058, 32'h0);
    rchk("flag kept", 12'h198, 32'h40);
    chk("irq off", 32'h0, {31'h0, irq_o});
    xfer(1'b1, 12'h198, 32'h1FF);
    @(posedge clk_i);
    ptp_clock_i <= 64'h100;
    rchk("timer flag", 12'h198, 32'h1);
    xfer(1'b1, 12'h060, 32'h7);
    @(posedge clk_i);
    pin_i <= 2'h3;
    repeat (5) @(posedge clk_i);
    rchk("pin capture", 12'h198, 32'h6);
    xfer(1'b1, 12'h198, 32'h6);
    xfer(1'b1, 12'h060, 32'h480);
    @(posedge clk_i);
    ptp_clock_i <= 64'h0;
    @(posedge clk_i);
    ptp_clock_i <= 64'h100;
    repeat (3) @(posedge clk_i);
    chk("pin flag", 32'h3, {30'h0, pin_oe_o[0], pin_o[0]});
    xfer(1'b1, 12'h198, 32'h1);
    @(posedge clk_i);
    chk("pin flag clr", 32'h2, {30'h0, pin_oe_o[0], pin_o[0]});
    xfer(1'b1, 12'h100, 32'hFFFF_FFFF);
    rchk("unmapped", 12'h100, 32'h0);
    xfer(1'b1, 12'h060, 32'h1D00);
    rchk("pin cfg rw", 12'h060, 32'h1D00);
    @(posedge clk_i);
    ptp_clock_i <= 64'h0;
    @(posedge clk_i);
    ptp_clock_i <= 64'h100;
    repeat (3) @(posedge clk_i);
    chk("pin pulse tog", 32'hE, {28'h0, pin_oe_o, pin_o});
    @(posedge clk_i);
    chk("pin pulse end", 32'hF, {28'h0, pin_oe_o, pin_o});
    xfer(1'b1, 12'h198, 32'h0001_0000);
    chk("irq before rst", 32'h1, {31'h0, irq_o});
    @(posedge clk_i);
    rst_i       <= 1'b1;
    ptp_clock_i <= 64'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk("flags after rst", 12'h198, 32'h0);
    rchk("sys_en after rst", 12'h05C, 32'h0);
    chk("irq after rst", 32'h0, {31'h0, irq_o});
    chk("pins after rst", 32'h0, {28'h0, pin_oe_o, pin_o});
    summarize();
  end
endmodule : tb_ptpirq_top
`default_nettype wire
